//--- hdl/dadc_input_ctrl.sv
// Input selection, sampling sequence and result coding of the dual converter.
// Assumes chip select and serial clock are synchronous levels, sampled here.
//
// Notes on behaviour
// - Low select: three pairs; high: six singles
// - Select changes take effect immediately
// - Mode change by address restarts acquisition
// - Address decodes single input or pair
// - Range low one reference, high double
// - Twos complement for full differential or doubled
// - Twelve bits, LSB is span over 4096
// - Sample both converters at chip select fall
// - Fourteen clocks complete and deliver result
`timescale 1ns/100ps
module dadc_input_ctrl
  import dadc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic single_true_mode_a_select_i,
  input wire logic [2:0] chan_addr_i,
  input wire logic range_sel_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [RES_BITS-1:0] conv_a_raw_i,
  input wire logic [RES_BITS-1:0] conv_b_raw_i,
  output dadc_mux_t mux_o,
  output logic span_double_o,
  output logic track_o,
  output logic sample_o,
  output logic acq_restart_o,
  output logic conv_corrupt_o,
  output dadc_cfg_t cfg_o,
  output logic twos_o,
  output logic [2:0] lsb_units_o,
  output logic result_valid_o,
  output logic [RES_BITS-1:0] result_a_o,
  output logic [RES_BITS-1:0] result_b_o
);

  // ----------------------------------------
  // Edge detection and live decode
  // ----------------------------------------
  dadc_mux_t mux_now;
  dadc_mux_t mux_reg;
  dadc_cfg_t cfg_reg;
  dadc_cfg_t cfg_next;
  dadc_state_t state_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [CNT_W-1:0] rise_cnt_reg;
  logic [CNT_W-1:0] fall_cnt_reg;
  logic span_reg;
  logic sample_reg;
  logic restart_reg;
  logic corrupt_reg;
  logic valid_reg;
  logic twos_reg;
  logic [2:0] lsb_reg;
  logic [RES_BITS-1:0] held_a_reg;
  logic [RES_BITS-1:0] held_b_reg;
  logic [RES_BITS-1:0] res_a_reg;
  logic [RES_BITS-1:0] res_b_reg;
  logic converting;

  dadc_chan_decode u_decode (
    .single_true_mode_a_select_i(single_true_mode_a_select_i),
    .chan_addr_i(chan_addr_i),
    .mux_o(mux_now)
  );

  assign cs_fall = cs_n_reg & ~cs_n_i;
  assign cs_rise = ~cs_n_reg & cs_n_i;
  assign sclk_rise = ~sclk_reg & sclk_i;
  assign sclk_fall = sclk_reg & ~sclk_i;
  assign converting = (state_reg == ST_HOLD) || (state_reg == ST_RETRACK);
  assign cfg_next = '{single: single_true_mode_a_select_i, pseudo: mux_now.pseudo, span_double: range_sel_i};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
    end else begin
      cs_n_reg <= cs_n_i;
      sclk_reg <= sclk_i;
    end
  end

  // ----------------------------------------
  // Multiplexer setting follows the pins
  // ----------------------------------------
  // No shadowing here: a mid-conversion change reaches the switches at once
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mux_reg <= '0;
      span_reg <= 1'b0;
    end else begin
      mux_reg <= mux_now;
      span_reg <= range_sel_i;
    end
  end

  // Full versus pseudo flip by address alone restarts acquisition
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= ~mux_now.single & ~mux_reg.single & (mux_now.pseudo != mux_reg.pseudo);
    end
  end

  // Sticky until next sample; a change at that same edge does not set it, as hold starts a cycle later
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      corrupt_reg <= 1'b0;
    end else if (state_reg == ST_HOLD && mux_now.single != mux_reg.single) begin
      corrupt_reg <= 1'b1;
    end else if (cs_fall) begin
      corrupt_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Conversion sequence
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end else if (sclk_rise && rise_cnt_reg + CNT_ONE == TRACK_RISE_EDGE) begin
            state_reg <= ST_RETRACK;
          end
        end
        ST_RETRACK: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end else if (sclk_fall && fall_cnt_reg + CNT_ONE == RESULT_FALL_EDGE) begin
            state_reg <= ST_RESULT;
          end
        end
        default: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || cs_fall) begin
      rise_cnt_reg <= CNT_ZERO;
      fall_cnt_reg <= CNT_ZERO;
    end else if (converting) begin
      if (sclk_rise) begin
        rise_cnt_reg <= rise_cnt_reg + CNT_ONE;
      end
      if (sclk_fall) begin
        fall_cnt_reg <= fall_cnt_reg + CNT_ONE;
      end
    end
  end

  // Configuration and both inputs frozen at the sampling instant
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_reg <= '0;
      held_a_reg <= '0;
      held_b_reg <= '0;
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= cs_fall;
      if (cs_fall) begin
        cfg_reg <= cfg_next;
        held_a_reg <= conv_a_raw_i;
        held_b_reg <= conv_b_raw_i;
      end
    end
  end

  // ----------------------------------------
  // Result coding
  // ----------------------------------------
  // Coding uses latched config, so late range edits cannot flip a result
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      valid_reg <= 1'b0;
      twos_reg <= 1'b0;
      lsb_reg <= LSB_UNITS_ONE;
      res_a_reg <= '0;
      res_b_reg <= '0;
    end else if (state_reg == ST_RETRACK && !cs_rise && sclk_fall && fall_cnt_reg + CNT_ONE == RESULT_FALL_EDGE) begin
      valid_reg <= 1'b1;
      twos_reg <= dadc_twos(cfg_reg);
      lsb_reg <= dadc_lsb_units(cfg_reg);
      res_a_reg <= dadc_encode(held_a_reg, dadc_twos(cfg_reg));
      res_b_reg <= dadc_encode(held_b_reg, dadc_twos(cfg_reg));
    end else if (cs_rise || cs_fall) begin
      valid_reg <= 1'b0;
    end
  end

  assign mux_o = mux_reg;
  assign span_double_o = span_reg;
  assign track_o = ~converting | (state_reg == ST_RETRACK);
  assign sample_o = sample_reg;
  assign acq_restart_o = restart_reg;
  assign conv_corrupt_o = corrupt_reg;
  assign cfg_o = cfg_reg;
  assign twos_o = twos_reg;
  assign lsb_units_o = lsb_reg;
  assign result_valid_o = valid_reg;
  assign result_a_o = res_a_reg;
  assign result_b_o = res_b_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cs_fall;
    cs_n_reg && !cs_n_i && state_reg == ST_IDLE;
  endsequence

  sequence s_last_fall;
    state_reg == ST_RETRACK && !cs_rise && sclk_fall && fall_cnt_reg == RESULT_FALL_EDGE - CNT_ONE;
  endsequence

  property p_sample;
    @(posedge sys_clk_i) disable iff (srst_i) s_cs_fall |=> sample_o && !track_o && cfg_o == $past(cfg_next);
  endproperty
  a_sample: assert property (p_sample) else $error("sample or latch missed at select fall");

  property p_result;
    @(posedge sys_clk_i) disable iff (srst_i) s_last_fall |=> result_valid_o && track_o
      && result_a_o == dadc_encode($past(held_a_reg), dadc_twos(cfg_o));
  endproperty
  a_result: assert property (p_result) else $error("result not delivered at fourteenth fall");

  property p_no_early;
    @(posedge sys_clk_i) disable iff (srst_i) s_cs_fall ##1 (!cs_rise)[*3] |-> !result_valid_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("result valid too early");

  property p_coding;
    @(posedge sys_clk_i) disable iff (srst_i) $rose(result_valid_o) |->
      twos_o == (cfg_o.span_double || (!cfg_o.single && !cfg_o.pseudo)) && lsb_units_o == dadc_lsb_units(cfg_o);
  endproperty
  a_coding: assert property (p_coding) else $error("output coding or lsb size wrong");

  property p_single;
    @(posedge sys_clk_i) disable iff (srst_i) 1'b1 |=> mux_o.single == $past(single_true_mode_a_select_i)
      && mux_o.neg_gnd == $past(single_true_mode_a_select_i) && span_double_o == $past(range_sel_i);
  endproperty
  a_single: assert property (p_single) else $error("input type not followed at once");

  property p_decode;
    @(posedge sys_clk_i) disable iff (srst_i) !single_true_mode_a_select_i && chan_addr_i[2:1] <= PAIR_LAST |=>
      mux_o.pos_input == {$past(chan_addr_i[2:1]), 1'b0} && mux_o.neg_input == {$past(chan_addr_i[2:1]), 1'b1}
      && mux_o.pseudo == $past(chan_addr_i[0]);
  endproperty
  a_decode: assert property (p_decode) else $error("pair decode wrong");

  property p_bad_addr;
    @(posedge sys_clk_i) disable iff (srst_i) single_true_mode_a_select_i && chan_addr_i > SGL_ADDR_LAST |=>
      mux_o.addr_bad && mux_o.pos_input == SGL_ADDR_LAST;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unlisted single address not flagged");

  property p_restart;
    @(posedge sys_clk_i) disable iff (srst_i) !single_true_mode_a_select_i && $stable(single_true_mode_a_select_i)
      && $changed(chan_addr_i[0]) |=> acq_restart_o;
  endproperty
  a_restart: assert property (p_restart) else $error("acquisition restart missing");

  property p_hold_result;
    @(posedge sys_clk_i) disable iff (srst_i) result_valid_o && !cs_rise |=> result_valid_o && $stable(result_a_o);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result changed before select rise");

endmodule // dadc_input_ctrl

//--- hdl/dadc_pkg.sv
// Shared constants, carriers and helpers for the dual converter input logic.
// Assumes one system clock; all pins arrive synchronous to it.
package dadc_pkg;

  // ----------------------------------------
  // Sizes and edge counts
  // ----------------------------------------
  localparam int RES_BITS = 12;
  localparam int CODE_COUNT = 4096;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] TRACK_RISE_EDGE = 5'h0d;
  localparam logic [CNT_W-1:0] RESULT_FALL_EDGE = 5'h0e;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [2:0] SGL_ADDR_LAST = 3'h5;
  localparam logic [1:0] PAIR_LAST = 2'h2;
  localparam logic [2:0] LSB_UNITS_ONE = 3'h1;
  localparam logic [2:0] LSB_UNITS_TWO = 3'h2;
  localparam logic [2:0] LSB_UNITS_FOUR = 3'h4;
  localparam logic [2:0] INPUT_GND = 3'h7;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Input numbers 0..5 stand for inputs 1..6 of each converter.
  typedef struct packed {
    logic single;
    logic pseudo;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic neg_gnd;
    logic addr_bad;
  } dadc_mux_t;

  typedef struct packed {
    logic single;
    logic pseudo;
    logic span_double;
  } dadc_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_RETRACK,
    ST_RESULT
  } dadc_state_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic dadc_twos(input dadc_cfg_t c);
    return c.span_double | (~c.single & ~c.pseudo);
  endfunction

  // LSB size in units of the reference over the code count
  function automatic logic [2:0] dadc_lsb_units(input dadc_cfg_t c);
    logic [2:0] base;
    base = c.single ? LSB_UNITS_ONE : LSB_UNITS_TWO;
    if (c.span_double) begin
      return (base == LSB_UNITS_ONE) ? LSB_UNITS_TWO : LSB_UNITS_FOUR;
    end
    return base;
  endfunction

  // Raw converter code is offset binary; twos complement flips the top bit
  function automatic logic [RES_BITS-1:0] dadc_encode(input logic [RES_BITS-1:0] raw, input logic twos);
    return twos ? {~raw[RES_BITS-1], raw[RES_BITS-2:0]} : raw;
  endfunction

endpackage

//--- hdl/dadc_chan_decode.sv
// Channel address and input type decode, shared by both converters.
// Assumes pins are static levels; purely combinational.
`timescale 1ns/100ps
module dadc_chan_decode
  import dadc_pkg::*;
(
  input wire logic single_true_mode_a_select_i,
  input wire logic [2:0] chan_addr_i,
  output dadc_mux_t mux_o
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    mux_o = '0;
    mux_o.single = single_true_mode_a_select_i;
    if (single_true_mode_a_select_i) begin
      mux_o.neg_gnd = 1'b1;
      mux_o.neg_input = INPUT_GND;
      if (chan_addr_i > SGL_ADDR_LAST) begin
        // Unlisted codes park on the last input and raise a flag
        mux_o.pos_input = SGL_ADDR_LAST;
        mux_o.addr_bad = 1'b1;
      end else begin
        mux_o.pos_input = chan_addr_i;
      end
    end else begin
      mux_o.pseudo = chan_addr_i[0];
      if (chan_addr_i[2:1] > PAIR_LAST) begin
        mux_o.pos_input = {PAIR_LAST, 1'b0};
        mux_o.addr_bad = 1'b1;
      end else begin
        mux_o.pos_input = {chan_addr_i[2:1], 1'b0};
      end
      mux_o.neg_input = {mux_o.pos_input[2:1], 1'b1};
    end
  end

endmodule // dadc_chan_decode

//--- tb/dadc_host_model.sv
// Host side model: drives the converter pins, chip select and serial clock.
// Assumes the bench calls its tasks just after a rising edge of sys_clk_i.
`timescale 1ns/100ps
module dadc_host_model
  import dadc_pkg::*;
#(
  parameter int ACQ_CYC = 4,
  parameter int HALF_CYC = 3
) (
  input wire logic sys_clk_i,
  output logic single_true_mode_a_select_o,
  output logic [2:0] chan_addr_o,
  output logic range_sel_o,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [RES_BITS-1:0] raw_a_o,
  output logic [RES_BITS-1:0] raw_b_o
);
  // ----------------------------------------
  // Idle levels; serial clock stands low outside frames
  // ----------------------------------------
  initial begin
    single_true_mode_a_select_o = 1'h0;
    chan_addr_o = 3'h0;
    range_sel_o = 1'h0;
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    raw_a_o = 12'h000;
    raw_b_o = 12'h000;
  end

  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  task automatic setup(input logic sel, input logic [2:0] addr, input logic rng,
                       input logic [RES_BITS-1:0] ra, input logic [RES_BITS-1:0] rb);
    single_true_mode_a_select_o <= sel;
    chan_addr_o <= addr;
    range_sel_o <= rng;
    raw_a_o <= ra;
    raw_b_o <= rb;
    repeat (ACQ_CYC) @(posedge sys_clk_i);
  endtask

  task automatic set_pins(input logic sel, input logic [2:0] addr, input logic rng);
    single_true_mode_a_select_o <= sel;
    chan_addr_o <= addr;
    range_sel_o <= rng;
    @(posedge sys_clk_i);
  endtask

  task automatic start();
    cs_n_o <= 1'h0;
    repeat (HALF_CYC) @(posedge sys_clk_i);
  endtask

  // Several sys clocks per phase so every level is seen
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'h1;
      repeat (HALF_CYC) @(posedge sys_clk_i);
      sclk_o <= 1'h0;
      repeat (HALF_CYC) @(posedge sys_clk_i);
    end
  endtask

  // Raw codes move once the frame ends, so stale capture shows
  task automatic stop();
    cs_n_o <= 1'h1;
    raw_a_o <= ~raw_a_o;
    raw_b_o <= ~raw_b_o;
    repeat (2) @(posedge sys_clk_i);
  endtask
endmodule // dadc_host_model

//--- tb/tb_top.sv
// Self-checking bench for the dual converter input logic.
// Assumes the host model drives all pins; expectations come from the coding table.
`timescale 1ns/100ps
module tb_top;
  import dadc_pkg::*;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic sel, rng, cs_n, sclk;
  logic [2:0] addr;
  logic [RES_BITS-1:0] raw_a, raw_b, res_a, res_b;
  dadc_mux_t mux;
  dadc_cfg_t cfg;
  logic span_double, track, sample, acq_restart, corrupt, twos, valid;
  logic [2:0] lsb;
  int error_cnt = 0;
  int compares = 0;
  int samp_cnt = 0;
  int rst_cnt = 0;

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (sample === 1'h1) samp_cnt++;
    if (acq_restart === 1'h1) rst_cnt++;
  end

  dadc_host_model u_host (.sys_clk_i(sys_clk), .single_true_mode_a_select_o(sel), .chan_addr_o(addr),
    .range_sel_o(rng), .cs_n_o(cs_n), .sclk_o(sclk), .raw_a_o(raw_a), .raw_b_o(raw_b));

  dadc_input_ctrl u_dut (.sys_clk_i(sys_clk), .srst_i(srst), .single_true_mode_a_select_i(sel),
    .chan_addr_i(addr), .range_sel_i(rng), .cs_n_i(cs_n), .sclk_i(sclk), .conv_a_raw_i(raw_a),
    .conv_b_raw_i(raw_b), .mux_o(mux), .span_double_o(span_double), .track_o(track),
    .sample_o(sample), .acq_restart_o(acq_restart), .conv_corrupt_o(corrupt), .cfg_o(cfg),
    .twos_o(twos), .lsb_units_o(lsb), .result_valid_o(valid), .result_a_o(res_a), .result_b_o(res_b));

  // ----------------------------------------
  // Compare, verdict, expected decode
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic dadc_mux_t exp_mux(input logic s, input logic [2:0] a);
    dadc_mux_t m;
    logic [1:0] p;
    m = '0;
    m.single = s;
    if (s) begin
      m.addr_bad = (a > 3'h5);
      m.pos_input = m.addr_bad ? 3'h5 : a;
      m.neg_input = 3'h7;
      m.neg_gnd = 1'h1;
    end else begin
      p = a[2:1];
      m.addr_bad = (p == 2'h3);
      if (m.addr_bad) p = 2'h2;
      m.pos_input = {p, 1'h0};
      m.neg_input = {p, 1'h1};
      m.pseudo = a[0];
    end
    return m;
  endfunction

  // ----------------------------------------
  // Watchdog: about twenty-five times the expected run
  // ----------------------------------------
  initial begin
    #400000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [RES_BITS-1:0] ra, rb;
    logic tw;
    int s0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    u_host.setup(1'h1, 3'h2, 1'h0, 12'h123, 12'h456);
    u_host.start();
    u_host.clocks(4);
    u_host.set_pins(1'h0, 3'h2, 1'h0);
    u_host.clocks(10);
    check(corrupt, 1'h1, "select change in hold");
    u_host.stop();
    u_host.setup(1'h1, 3'h0, 1'h0, 12'h0ff, 12'h0ee);
    u_host.start();
    u_host.clocks(13);
    check(track, 1'h1, "track after 13th rise");
    check(valid, 1'h0, "abort before 14th fall");
    u_host.stop();
    check(valid, 1'h0, "abort leaves no result");
    u_host.setup(1'h0, 3'h0, 1'h0, 12'h000, 12'h000);
    s0 = rst_cnt;
    u_host.set_pins(1'h0, 3'h1, 1'h0);
    repeat (4) @(posedge sys_clk);
    check(16'(rst_cnt - s0), 16'h1, "mode change restart");
    s0 = rst_cnt;
    u_host.set_pins(1'h1, 3'h0, 1'h0);
    repeat (4) @(posedge sys_clk);
    check(16'(rst_cnt - s0), 16'h0, "no restart in single");
    // Every select, address and range combination
    for (int i = 0; i < 32; i++) begin
      ra = 12'(12'h800 + 91 * i);
      rb = ~ra;
      tw = i[3] | (~i[4] & ~i[0]);
      u_host.setup(i[4], i[2:0], i[3], ra, rb);
      check(mux, exp_mux(i[4], i[2:0]), "mux decode");
      check(span_double, i[3], "range copy");
      s0 = samp_cnt;
      u_host.start();
      u_host.clocks(6);
      check(track, 1'h0, "hold after select fall");
      // Range may move after the sixth fall; coding must not follow
      u_host.set_pins(i[4], i[2:0], ~i[3]);
      u_host.clocks(8);
      check(16'(samp_cnt - s0), 16'h1, "one sample pulse");
      check(valid, 1'h1, "result valid");
      check(corrupt, 1'h0, "corrupt cleared");
      check(cfg, {i[4], ~i[4] & i[0], i[3]}, "latched config");
      check(twos, tw, "coding choice");
      check(lsb, (i[4] ? 3'h1 : 3'h2) << i[3], "lsb units");
      check(res_a, tw ? (ra ^ 12'h800) : ra, "result a");
      check(res_b, tw ? (rb ^ 12'h800) : rb, "result b");
      u_host.stop();
      check(valid, 1'h0, "valid drops on select rise");
    end
    wrap_up();
  end
endmodule // tb_top
